// ===== hdl/port_h_data_bus_pin_select.sv
// Purpose: Selects general I/O or data bus use for port pins 10 to 3
// Assumes: Mode inputs are static straps on the same clock as the bus
// Notes: Select outputs are registered; 1 means data bus line
//
// Implementation choices: the placing of the registers and the strobed register port.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module port_h_data_bus_pin_select
    import pin_select_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Chip mode straps
    input wire logic expanded_mode,
    input wire logic rom_enabled,
    input wire logic area0_16bit,
    // Pin function selects, 1 = data bus line
    output logic [SEL_HI:SEL_LO] data_bus_sel
);

    //////////////////////////////////////////////////////////////////////////
    // Field register, its next value and the pin map
    logic [SEL_HI:SEL_LO] func_sel_r;
    logic [SEL_HI:SEL_LO] func_sel_nxt;
    logic [SEL_HI:SEL_LO] pin_sel_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    chip_mode_e chip_mode;

    // Decode of the mode field register index, shared by write and read
    function automatic logic field_hit(input logic [ADDR_W-1:0] addr);
        return addr == FUNC_SEL_ADDR;
    endfunction

    // Chip mode decode from strap levels
    always_comb begin
        if (!expanded_mode) begin
            chip_mode = MODE_SINGLE;
        end else if (rom_enabled) begin
            chip_mode = MODE_EXP_ROM_ON;
        end else begin
            chip_mode = MODE_EXP_ROM_OFF;
        end
    end

    // Next value of the mode fields
    always_comb begin
        func_sel_nxt = func_sel_r;
        if (reg_wr && field_hit(reg_addr)) begin
            func_sel_nxt = reg_wdata[SEL_HI:SEL_LO];
        end
    end

    // Mode field register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            func_sel_r <= FUNC_SEL_RST;
        end else begin
            func_sel_r <= func_sel_nxt;
        end
    end

    // Pin function per mode; bit n only affects pin n
    always_comb begin
        unique case (chip_mode)
            MODE_SINGLE: pin_sel_nxt = '0;
            MODE_EXP_ROM_ON: pin_sel_nxt = func_sel_r;
            MODE_EXP_ROM_OFF: begin
                if (area0_16bit) begin
                    pin_sel_nxt = FORCE_16BIT;
                end else begin
                    pin_sel_nxt = func_sel_r | FORCE_8BIT;
                end
            end
            default: pin_sel_nxt = '0;
        endcase
    end

    // Registered select output
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            data_bus_sel <= '0;
        end else begin
            data_bus_sel <= pin_sel_nxt;
        end
    end

    // Read mux: fields and the live pin function
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            if (field_hit(reg_addr)) begin
                rdata_nxt[SEL_HI:SEL_LO] = func_sel_r;
            end else if (reg_addr == STATUS_ADDR) begin
                rdata_nxt[SEL_HI:SEL_LO] = data_bus_sel;
            end
        end
    end

    // Read data register, valid one cycle after strobe
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Single-chip keeps every pin on general I/O
    a_single_all_gpio: assert property (
        $past(!expanded_mode) |-> data_bus_sel == '0)
        else $error("single-chip pin not gpio");

    // ROM off forces the low pins onto the bus
    a_romoff_low_bus: assert property (
        $past(expanded_mode && !rom_enabled) |-> &data_bus_sel[7:3])
        else $error("low pins not bus with rom off");

    // A 16-bit area forces the high pins as well
    a_wide_high_bus: assert property (
        $past(expanded_mode && !rom_enabled && area0_16bit)
        |-> &data_bus_sel[10:8])
        else $error("high pins not bus in 16-bit");

    // An 8-bit area lets the high fields choose
    a_narrow_follow: assert property (
        $past(expanded_mode && !rom_enabled && !area0_16bit)
        |-> data_bus_sel[10:8] == $past(func_sel_r[10:8]))
        else $error("8-bit high pins wrong");

    // ROM on hands every pin to its own field
    a_romon_follow: assert property (
        $past(expanded_mode && rom_enabled)
        |-> data_bus_sel == $past(func_sel_r))
        else $error("rom on pins not following fields");

    // A field write reaches the pins two edges later
    a_write_then_mux: assert property (
        reg_wr && reg_addr == FUNC_SEL_ADDR && expanded_mode && rom_enabled
        ##1 expanded_mode && rom_enabled
        |=> data_bus_sel == $past(reg_wdata[SEL_HI:SEL_LO], 2))
        else $error("mux not updated after write");

    // Field register takes the written bits
    a_field_write: assert property (
        reg_wr && reg_addr == FUNC_SEL_ADDR
        |=> func_sel_r == $past(reg_wdata[SEL_HI:SEL_LO]))
        else $error("field write not taken");

    // Fields hold without a write to their index
    a_field_steady: assert property (
        !(reg_wr && reg_addr == FUNC_SEL_ADDR) |=> $stable(func_sel_r))
        else $error("field changed without write");

    // Writes to other indices leave the fields alone
    a_other_wr_ignored: assert property (
        reg_wr && reg_addr != FUNC_SEL_ADDR |=> $stable(func_sel_r))
        else $error("field changed by other index");

    // Pins 9 to 3 depend on their own fields only
    a_pin_isolated: assert property (
        $stable(func_sel_r[9:3]) && $stable({expanded_mode, rom_enabled})
        && expanded_mode && rom_enabled |=> $stable(data_bus_sel[9:3]))
        else $error("pin changed by other field");

    // A field change flips only its own pin
    a_change_own_pin: assert property (
        expanded_mode && rom_enabled && $stable({expanded_mode, rom_enabled})
        |=> (data_bus_sel ^ $past(data_bus_sel))
            == ($past(func_sel_r) ^ $past(func_sel_r, 2)))
        else $error("field change moved another pin");

    // Field read returns the fields at bits 10 to 3
    a_read_back: assert property (
        reg_rd && reg_addr == FUNC_SEL_ADDR
        |=> reg_rdata == {5'h00, $past(func_sel_r), 3'h0})
        else $error("read data mismatch");

    // Status read returns the live pin function
    a_status_read: assert property (
        reg_rd && reg_addr == STATUS_ADDR
        |=> reg_rdata == {5'h00, $past(data_bus_sel), 3'h0})
        else $error("status read mismatch");

    // Unmapped indices read zero
    a_unmapped_read: assert property (
        reg_rd && reg_addr != FUNC_SEL_ADDR && reg_addr != STATUS_ADDR
        |=> reg_rdata == '0)
        else $error("unmapped index read not zero");

    // Read data falls back to zero without a read
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero when idle");

    // Bits outside the fields always read zero
    a_rdata_pad: assert property (
        reg_rdata[DATA_W-1:SEL_HI+1] == '0 && reg_rdata[SEL_LO-1:0] == '0)
        else $error("unused read bits not zero");

    // Main scenarios
    c_single: cover property (!expanded_mode ##1 data_bus_sel == '0);
    c_romoff8: cover property (expanded_mode && !rom_enabled && !area0_16bit);
    c_romoff16: cover property (expanded_mode && !rom_enabled && area0_16bit);
    c_romon_wr: cover property (
        expanded_mode && rom_enabled && reg_wr && reg_addr == FUNC_SEL_ADDR);
    c_status_rd: cover property (reg_rd && reg_addr == STATUS_ADDR);

endmodule
`default_nettype wire

// ===== hdl/pin_select_pkg.sv
// Purpose: Shared constants for the data bus pin select block
// Assumes: One clock, plain register port with one-cycle read latency
// Notes: Mode fields occupy bits 10 to 3 of one 16-bit register
`default_nettype none
package pin_select_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SEL_LO = 3;
    localparam int SEL_HI = 10;
    localparam int SEL_W = SEL_HI - SEL_LO + 1;
    // Register indices
    localparam logic [ADDR_W-1:0] FUNC_SEL_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h1;
    // Reset value of all mode fields
    localparam logic [SEL_W-1:0] FUNC_SEL_RST = 8'h00;
    // Pins forced to data bus when ROM disabled and area 0 is 8 bits wide
    localparam logic [SEL_W-1:0] FORCE_8BIT = 8'h1F;
    // Pins forced to data bus when ROM disabled and area 0 is 16 bits wide
    localparam logic [SEL_W-1:0] FORCE_16BIT = 8'hFF;
    // Chip operating modes
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_EXP_ROM_ON = 2'b01,
        MODE_EXP_ROM_OFF = 2'b10
    } chip_mode_e;
endpackage
`default_nettype wire

// ===== verification/pin_owner_model.sv
// Purpose: Far-side model of the pin owners behind the select lines
// Assumes: Select lines are registered on the bus clock
// Notes: Counts pins currently handed to the external data bus
`default_nettype none
module pin_owner_model (
    input wire logic [10:3] data_bus_sel,
    output logic [3:0] bus_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bus controller owns every pin whose select is high
    always_comb bus_pins = 4'($countones(data_bus_sel));
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the data bus pin select block
// Assumes: Mode inputs change only right after a rising edge
// Notes: Select patterns prove each field steers only its own pin
`default_nettype none
module tb_top import pin_select_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
    logic expanded_mode = 0, rom_enabled = 0, area0_16bit = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata, d;
    logic [SEL_HI:SEL_LO] data_bus_sel;
    logic [3:0] bus_pins;
    logic [7:0] pats [4] = '{8'h00, 8'hA5, 8'h5A, 8'hFF};
    int n_mismatch = 0, cmp_count = 0;
    always #25 mclk = ~mclk;
    port_h_data_bus_pin_select port_h_data_bus_pin_select_inst (.mclk(mclk),
        .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .expanded_mode(expanded_mode), .rom_enabled(rom_enabled),
        .area0_16bit(area0_16bit), .data_bus_sel(data_bus_sel));
    pin_owner_model pin_owner_model_inst (.data_bus_sel(data_bus_sel),
        .bus_pins(bus_pins));
    //////////////////////////////////////////////////////////////////////
    // Shared compare, bus cycles and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic set_mode(input logic e, input logic r, input logic w);
        @(posedge mclk);
        expanded_mode <= e;
        rom_enabled <= r;
        area0_16bit <= w;
        @(posedge mclk);
        #1;
    endtask
    task automatic finish_test();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    // Reset values and register access
    task automatic t_regs();
        rd(FUNC_SEL_ADDR);
        check(d, 16'h0000);
        check({8'h00, data_bus_sel}, 16'h0000);
        set_mode(1'b1, 1'b1, 1'b0);
        check({8'h00, data_bus_sel}, 16'h0000);
        set_mode(1'b1, 1'b0, 1'b0);
        check({8'h00, data_bus_sel}, 16'h001F);
        wr(FUNC_SEL_ADDR, 16'hFFFF);
        rd(FUNC_SEL_ADDR);
        check(d, 16'h07F8);
        @(posedge mclk);
        #1 check(reg_rdata, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rd(4'hF);
        check(d, 16'h0000);
    endtask
    // Every mode against several field patterns
    task automatic t_modes();
        foreach (pats[i]) begin
            set_mode(1'b1, 1'b1, 1'b0);
            wr(FUNC_SEL_ADDR, {5'h00, pats[i], 3'h0});
            @(posedge mclk);
            #1 check({8'h00, data_bus_sel}, {8'h00, pats[i]});
            check({12'h000, bus_pins}, 16'($countones(pats[i])));
            set_mode(1'b1, 1'b0, 1'b0);
            check({8'h00, data_bus_sel},
                {8'h00, pats[i] | 8'h1F});
            set_mode(1'b1, 1'b0, 1'b1);
            check({8'h00, data_bus_sel}, 16'h00FF);
            rd(STATUS_ADDR);
            check(d, 16'h07F8);
            set_mode(1'b0, 1'b0, 1'b0);
            check({8'h00, data_bus_sel}, 16'h0000);
        end
    endtask
    // Mid-run reset clears fields written before it
    task automatic t_reset();
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd(FUNC_SEL_ADDR);
        check(d, 16'h0000);
        set_mode(1'b1, 1'b1, 1'b0);
        check({8'h00, data_bus_sel}, 16'h0000);
    endtask
    // Hang guard and main sequence
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        t_modes();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
